// ---- tx_fifo_err_pkg.sv ----
// Package with register map, field positions and reset values for the transmit FIFO error flag block
package tx_fifo_err_pkg;
    // Register byte addresses
    localparam logic [7:0] TX_FLAG_REG_ADDR = 8'h04;
    localparam logic [7:0] TX_CTRL_ADDR     = 8'h00;
    localparam logic [7:0] IRQ_STATUS_ADDR  = 8'h08;
    localparam logic [7:0] IRQ_ENABLE_ADDR  = 8'h0C;
    localparam logic [7:0] IRQ_CLEAR_ADDR   = 8'h10;
    localparam logic [7:0] FIFO_SIZE_ADDR   = 8'h14;
    // Flag register fields
    localparam int OVF_BIT  = 0;
    localparam int URF_BIT  = 1;
    localparam int FULL_BIT = 2;
    localparam int EMP_BIT  = 3;
    localparam int SET_LO   = 6;
    localparam logic [7:0] TX_FLAG_RESET = 8'h08;
    // Control register fields
    localparam int CLR_BIT = 0;
    localparam int ISO_BIT = 1;
    // Set index value meaning both data sets occupied
    localparam logic [1:0] SETS_BOTH = 2'h3;
    // Interrupt status bits
    localparam int IRQ_OVF = 0;
    localparam int IRQ_URF = 1;
    localparam int IRQ_NAK = 2;
    localparam int IRQ_W   = 3;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tx_fifo_err_pkg

// ---- usb_tx_fifo_error_flags.sv ----
// Transmit FIFO error flags, pointer locks and NAK gating with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Full indication always tracks current FIFO state in every endpoint mode.
// - Full is set when written byte count reaches FIFO size, dropped otherwise.
// - Underrun flag bit 1 sets when engine reads from an empty FIFO.
// - Error flags stay set until the FIFO clear control; no other write clears.
// - On underrun the read pointer stays locked at the empty position.
// - On overrun the write pointer stays locked where it stands, at the full position for a byte into a full FIFO.
// - While either error flag is set, every host transmit request gets NAK.
// - Isochronous: firmware-caused flag changes immediate, USB-caused changes wait for SOF.
// - Isochronous underrun posts to its flag at the next start-of-frame.
// - Overrun flag updates immediately, even in isochronous mode.
// - Overrun flag bit 0 sets when firmware writes a byte into a full FIFO.
// - Overrun also sets on byte count write while set index equals 11.
// - Flag register at offset 04H resets to 0000 1000B, only empty set.
module usb_tx_fifo_error_flags #(
    // Pointer width; the size register and counts hold one bit more
    parameter int PTR_W = 10
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]       awaddr,
    input  wire logic             awvalid,
    output var  logic             awready,
    input  wire logic [31:0]      wdata,
    input  wire logic [3:0]       wstrb,
    input  wire logic             wvalid,
    output var  logic             wready,
    output var  logic [1:0]       bresp,
    output var  logic             bvalid,
    input  wire logic             bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]       araddr,
    input  wire logic             arvalid,
    output var  logic             arready,
    output var  logic [31:0]      rdata,
    output var  logic [1:0]       rresp,
    output var  logic             rvalid,
    input  wire logic             rready,
    // Firmware data path strobes
    input  wire logic             fw_data_wr,
    input  wire logic             fw_count_wr,
    input  wire logic [1:0]       tx_set_index,
    // Serial interface engine side
    input  wire logic             sie_rd,
    input  wire logic             sie_in_token,
    input  wire logic             sof,
    // Engine answers and pointer views
    output var  logic             tx_nak,
    output var  logic [PTR_W-1:0] tx_rd_ptr,
    output var  logic [PTR_W-1:0] tx_wr_ptr,
    output var  logic             tx_full_flag,
    output var  logic             irq
);
    typedef struct packed {
        // Bus slave holding state
        logic             aw_got;
        logic [7:0]       aw_addr;
        logic             w_got;
        logic [31:0]      w_data;
        logic [3:0]       w_strb;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
        // Mode and configured size
        logic             iso;
        logic [PTR_W:0]   fifo_size;
        // Byte counts, one bit wider than the pointers
        logic [PTR_W:0]   wr_cnt;
        logic [PTR_W:0]   rd_cnt;
        // Error flags, pending underrun, full indication and NAK answer
        logic             ovf;
        logic             urf;
        logic             urf_pend;
        logic             full;
        logic             nak;
        // Interrupt status, enable and output
        logic [tx_fifo_err_pkg::IRQ_W-1:0] irq_stat;
        logic [tx_fifo_err_pkg::IRQ_W-1:0] irq_en;
        logic             irq;
    } state_t;

    // Registered state and its next value
    state_t s_r;
    state_t s_nxt;

    // Per-cycle decodes shared by the groups below
    logic                                 wr_fire;
    logic                                 fw_clear;
    logic                                 data_wr_ok;
    logic                                 urf_event;
    logic                                 ovf_event;
    logic [7:0]                           flag_view;
    logic [tx_fifo_err_pkg::IRQ_W-1:0]    irq_set;

    // Next-state logic for bus slave, flags and pointers
    // One process computes every next value, so no field has two drivers
    always_comb begin
        s_nxt = s_r;
        // Answers stand until the master takes them
        s_nxt.rvalid = s_r.rvalid & ~rready;
        s_nxt.bvalid = s_r.bvalid & ~bready;
        // Address and data captured independently, in either order
        // Capture is on the first edge valid is seen; ready follows
        if (awvalid && !s_r.aw_got) begin
            s_nxt.aw_got  = 1'b1;
            s_nxt.aw_addr = awaddr;
        end
        if (wvalid && !s_r.w_got) begin
            s_nxt.w_got  = 1'b1;
            s_nxt.w_data = wdata;
            s_nxt.w_strb = wstrb;
        end
        // A write fires once address and data are both held
        // and the previous response has been taken
        wr_fire  = s_r.aw_got && s_r.w_got && !s_r.bvalid;
        fw_clear = wr_fire && s_r.w_strb[0] && (s_r.aw_addr == tx_fifo_err_pkg::TX_CTRL_ADDR)
                   && s_r.w_data[tx_fifo_err_pkg::CLR_BIT];
        // No interrupt event unless raised below
        irq_set  = '0;
        if (wr_fire) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = tx_fifo_err_pkg::RESP_OKAY;
            unique case (s_r.aw_addr)
                // Clear is self-acting; only the mode bit is kept
                tx_fifo_err_pkg::TX_CTRL_ADDR: begin
                    if (s_r.w_strb[0]) begin
                        s_nxt.iso = s_r.w_data[tx_fifo_err_pkg::ISO_BIT];
                    end
                end
                // Size sets where the full indication trips
                tx_fifo_err_pkg::FIFO_SIZE_ADDR: begin
                    if (s_r.w_strb[0]) begin
                        s_nxt.fifo_size = s_r.w_data[PTR_W:0];
                    end
                end
                // Enable mask for the level interrupt
                tx_fifo_err_pkg::IRQ_ENABLE_ADDR: begin
                    if (s_r.w_strb[0]) begin
                        s_nxt.irq_en = s_r.w_data[tx_fifo_err_pkg::IRQ_W-1:0];
                    end
                end
                // Write one to clear status bits
                tx_fifo_err_pkg::IRQ_CLEAR_ADDR: begin
                    if (s_r.w_strb[0]) begin
                        s_nxt.irq_stat = s_r.irq_stat & ~s_r.w_data[tx_fifo_err_pkg::IRQ_W-1:0];
                    end
                end
                // Flag register is read/clear-only through the clear control
                tx_fifo_err_pkg::TX_FLAG_REG_ADDR,
                tx_fifo_err_pkg::IRQ_STATUS_ADDR: begin
                    s_nxt.bresp = tx_fifo_err_pkg::RESP_OKAY;
                end
                // Unmapped offsets answer with an error
                default: begin
                    s_nxt.bresp = tx_fifo_err_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Firmware byte write: pointer locks once full
        // A byte lands only below full and with no overrun standing,
        // so the write pointer parks at the full position, or where it stands after a count overrun
        data_wr_ok = fw_data_wr && !s_r.full && !s_r.ovf;
        // Byte into a full FIFO, or a count with both sets occupied
        ovf_event  = (fw_data_wr && s_r.full)
                     || (fw_count_wr && (tx_set_index == tx_fifo_err_pkg::SETS_BOTH));
        if (data_wr_ok) begin
            s_nxt.wr_cnt = s_r.wr_cnt + 1'b1;
        end
        // Overrun is firmware-caused, so it lands at once in either mode
        if (ovf_event) begin
            s_nxt.ovf = 1'b1;
        end

        // Engine read: an empty read locks the read pointer
        // Equal counts mean nothing left to send
        // Reads stay parked while an underrun stands or waits for SOF
        urf_event = sie_rd && (s_r.rd_cnt == s_r.wr_cnt);
        if (sie_rd && !urf_event && !s_r.urf && !s_r.urf_pend) begin
            s_nxt.rd_cnt = s_r.rd_cnt + 1'b1;
        end
        // Iso mode parks the event until the frame boundary
        if (urf_event) begin
            if (s_r.iso) begin
                s_nxt.urf_pend = 1'b1;
            end else begin
                s_nxt.urf = 1'b1;
            end
        end
        // Isochronous underrun shows only at start-of-frame
        // Engine activity never reaches the flag between frames
        if (sof && (s_r.urf_pend || (urf_event && s_r.iso))) begin
            s_nxt.urf      = 1'b1;
            s_nxt.urf_pend = 1'b0;
        end

        // Clear control drops flags, empties pointers, releases locks
        // An error in the very cycle of the clear still lands, so a
        // byte lost at that instant is not hidden from firmware
        if (fw_clear) begin
            s_nxt.ovf      = ovf_event;
            s_nxt.urf      = urf_event && (!s_r.iso || sof);
            s_nxt.urf_pend = urf_event && s_r.iso && !sof;
            s_nxt.wr_cnt   = '0;
            s_nxt.rd_cnt   = '0;
        end

        // Full follows the byte count in every mode
        // Computed from next counts so it never lags a write
        s_nxt.full = (s_nxt.wr_cnt >= s_nxt.fifo_size);

        // NAK answers while any error stands
        // One-cycle answer to each IN token
        s_nxt.nak = sie_in_token && (s_nxt.ovf || s_nxt.urf);

        // Sticky interrupt events; set beats a same-cycle clear
        // Rising error flags count as events; every NAK answer counts too
        irq_set[tx_fifo_err_pkg::IRQ_OVF] = s_nxt.ovf && !s_r.ovf;
        irq_set[tx_fifo_err_pkg::IRQ_URF] = s_nxt.urf && !s_r.urf;
        irq_set[tx_fifo_err_pkg::IRQ_NAK] = s_nxt.nak;
        s_nxt.irq_stat = s_nxt.irq_stat | irq_set;
        // Level output, high while any enabled status bit stands
        s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_en);

        // Read channel
        // Flag view built from registered state and the set index input; reserved bits read zero
        // A new read is refused while an answer still stands
        flag_view = '0;
        flag_view[tx_fifo_err_pkg::OVF_BIT]        = s_r.ovf;
        flag_view[tx_fifo_err_pkg::URF_BIT]        = s_r.urf;
        flag_view[tx_fifo_err_pkg::FULL_BIT]       = s_r.full;
        // Empty means no byte yet in the current data set
        flag_view[tx_fifo_err_pkg::EMP_BIT]        = (s_r.wr_cnt == '0);
        // Set index passes straight through from the data-set logic
        flag_view[tx_fifo_err_pkg::SET_LO +: 2]    = tx_set_index;
        if (arvalid && !s_r.rvalid) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = tx_fifo_err_pkg::RESP_OKAY;
            s_nxt.rdata  = '0;
            unique case (araddr)
                tx_fifo_err_pkg::TX_FLAG_REG_ADDR: begin
                    // Flags, empty and set index in the low byte
                    s_nxt.rdata[7:0] = flag_view;
                end
                tx_fifo_err_pkg::TX_CTRL_ADDR: begin
                    // Clear bit is self-acting and reads zero
                    s_nxt.rdata[tx_fifo_err_pkg::ISO_BIT] = s_r.iso;
                end
                tx_fifo_err_pkg::FIFO_SIZE_ADDR: begin
                    // Configured size as written
                    s_nxt.rdata[PTR_W:0] = s_r.fifo_size;
                end
                tx_fifo_err_pkg::IRQ_STATUS_ADDR: begin
                    // Sticky events, masked or not
                    s_nxt.rdata[tx_fifo_err_pkg::IRQ_W-1:0] = s_r.irq_stat;
                end
                tx_fifo_err_pkg::IRQ_ENABLE_ADDR: begin
                    // Enable mask as written
                    s_nxt.rdata[tx_fifo_err_pkg::IRQ_W-1:0] = s_r.irq_en;
                end
                tx_fifo_err_pkg::IRQ_CLEAR_ADDR: begin
                    // Write-only register reads zero
                    s_nxt.rdata = '0;
                end
                default: begin
                    // Unmapped offsets answer with an error
                    s_nxt.rresp = tx_fifo_err_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // State register; reset leaves only the empty indication set
    // Default size of 64 bytes follows from the pointer width
    // Synchronous reset, so its release needs no synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r           <= '0;
            s_r.fifo_size <= (PTR_W+1)'(1) << (PTR_W-4);
        end else begin
            s_r <= s_nxt;
        end
    end

    // Ready signals registered so outputs come from flip-flops
    // Each ready pulses one cycle after its valid is first held;
    // the payload was already captured on that first edge, so a
    // master holding its payload sees the same transfer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready  <= 1'b0;
            arready <= 1'b0;
        end else begin
            awready <= 1'b0;
            wready  <= 1'b0;
            arready <= 1'b0;
            // Write address
            if (awvalid && !s_r.aw_got && !awready) begin
                awready <= 1'b1;
            end
            // Write data
            if (wvalid && !s_r.w_got && !wready) begin
                wready <= 1'b1;
            end
            // Read address, refused while an answer stands
            if (arvalid && !s_r.rvalid && !arready) begin
                arready <= 1'b1;
            end
        end
    end

    // Bus answers
    assign bvalid       = s_r.bvalid;
    assign bresp        = s_r.bresp;
    assign rvalid       = s_r.rvalid;
    assign rdata        = s_r.rdata;
    assign rresp        = s_r.rresp;
    // Engine side and firmware side
    assign tx_nak       = s_r.nak;
    assign tx_rd_ptr    = s_r.rd_cnt[PTR_W-1:0];
    assign tx_wr_ptr    = s_r.wr_cnt[PTR_W-1:0];
    assign tx_full_flag = s_r.full;
    // Level interrupt
    assign irq          = s_r.irq;
endmodule : usb_tx_fifo_error_flags
`default_nettype wire

// ---- usb_tx_fifo_error_flags_monitor.sv ----
// Port-level checker for the transmit FIFO error flag block
`timescale 1ns/1ps
`default_nettype none
module usb_tx_fifo_error_flags_monitor #(
    parameter int PTR_W = 10
) (
    input wire logic             aclk,
    input wire logic             aresetn,
    input wire logic [7:0]       awaddr,
    input wire logic             awvalid,
    input wire logic             awready,
    input wire logic [31:0]      wdata,
    input wire logic             wvalid,
    input wire logic             wready,
    input wire logic             arvalid,
    input wire logic             rvalid,
    input wire logic             rready,
    input wire logic             fw_data_wr,
    input wire logic             sie_rd,
    input wire logic             sie_in_token,
    input wire logic             tx_nak,
    input wire logic [PTR_W-1:0] tx_rd_ptr,
    input wire logic [PTR_W-1:0] tx_wr_ptr,
    input wire logic             tx_full_flag
);
    logic ovf_h;
    logic clr_w;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Clear control written with address and data taken together
    assign clr_w = awvalid && awready && wvalid && wready
                   && awaddr == tx_fifo_err_pkg::TX_CTRL_ADDR && wdata[tx_fifo_err_pkg::CLR_BIT];

    // Overrun seen from the ports; only the clear control drops it
    always_ff @(posedge aclk) begin
        if (!aresetn || clr_w) ovf_h <= 1'b0;
        else if (fw_data_wr && tx_full_flag) ovf_h <= 1'b1;
    end

    a_wr_lock: assert property (fw_data_wr && tx_full_flag |=> $stable(tx_wr_ptr))
        else $error("write pointer moved on overrun");
    a_rd_lock: assert property (sie_rd && tx_rd_ptr == tx_wr_ptr |=> $stable(tx_rd_ptr))
        else $error("read pointer moved on underrun");
    a_full_cause: assert property ($rose(tx_full_flag) |-> $past(fw_data_wr))
        else $error("full rose without a data write");
    a_clear_empties: assert property (clr_w |-> ##[2:3] (tx_wr_ptr == '0 && tx_rd_ptr == '0 && !tx_full_flag))
        else $error("clear left pointers or full set");
    a_nak_on_error: assert property (ovf_h && sie_in_token |=> tx_nak)
        else $error("no NAK while overrun set");
    a_nak_cause: assert property (tx_nak |-> $past(sie_in_token))
        else $error("NAK without a request");
    a_read_answer: assert property (arvalid && !rvalid |=> rvalid)
        else $error("read answer late");
    a_read_single: assert property (rvalid && rready |=> !rvalid)
        else $error("read answer repeated");

    // Main scenarios reached
    c_overrun: cover property (fw_data_wr && tx_full_flag);
    c_nak: cover property (tx_nak);
    c_clear: cover property (clr_w);
endmodule : usb_tx_fifo_error_flags_monitor
bind usb_tx_fifo_error_flags usb_tx_fifo_error_flags_monitor #(.PTR_W(PTR_W)) mon_i (.aclk(aclk),
    .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wvalid(wvalid),
    .wready(wready), .arvalid(arvalid), .rvalid(rvalid), .rready(rready), .fw_data_wr(fw_data_wr),
    .sie_rd(sie_rd), .sie_in_token(sie_in_token), .tx_nak(tx_nak), .tx_rd_ptr(tx_rd_ptr),
    .tx_wr_ptr(tx_wr_ptr), .tx_full_flag(tx_full_flag));
`default_nettype wire

// ---- sie_model.sv ----
// Engine-side model: bench requests become one-cycle strobes, NAKs counted
`timescale 1ns/1ps
`default_nettype none
module sie_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [2:0] rq,
    input  wire logic       tx_nak,
    output var  logic       sie_rd,
    output var  logic       sie_in_token,
    output var  logic       sof,
    output var  logic [7:0] naks
);
    // Strobes held low in reset so no stray read lands
    always_ff @(posedge aclk) begin
        {sof, sie_in_token, sie_rd} <= aresetn ? rq : 3'h0;
        if (!aresetn) naks <= 8'h00;
        else if (tx_nak) naks <= naks + 8'h01;
    end
endmodule : sie_model
`default_nettype wire

// ---- usb_tx_fifo_error_flags_test.sv ----
// Self-checking bench for the transmit FIFO error flag block
`timescale 1ns/1ps
`default_nettype none
module usb_tx_fifo_error_flags_test;
    localparam logic [7:0] FLG = tx_fifo_err_pkg::TX_FLAG_REG_ADDR;
    localparam logic [7:0] CTL = tx_fifo_err_pkg::TX_CTRL_ADDR;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, fw_data_wr, fw_count_wr;
    logic        sie_rd, sie_in_token, sof, tx_nak, tx_full_flag, irq;
    logic [7:0]  awaddr, araddr, naks;
    logic [31:0] wdata, rdata, rv;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rr, rb, tx_set_index;
    logic [9:0]  tx_rd_ptr, tx_wr_ptr;
    logic [2:0]  rq;
    int          err_count, checked;

    usb_tx_fifo_error_flags usb_tx_fifo_error_flags_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .fw_data_wr(fw_data_wr),
        .fw_count_wr(fw_count_wr), .tx_set_index(tx_set_index), .sie_rd(sie_rd), .sie_in_token(sie_in_token),
        .sof(sof), .tx_nak(tx_nak), .tx_rd_ptr(tx_rd_ptr), .tx_wr_ptr(tx_wr_ptr), .tx_full_flag(tx_full_flag),
        .irq(irq));
    sie_model sie_model_i (.aclk(aclk), .aresetn(aresetn), .rq(rq), .tx_nak(tx_nak), .sie_rd(sie_rd),
        .sie_in_token(sie_in_token), .sof(sof), .naks(naks));

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    // Bus write; trailing edge keeps strobes from being set twice in one step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rb = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    // Firmware data (cnt=0) or byte count (cnt=1) strobes
    task automatic fw(input int n, input logic cnt);
        repeat (n) begin
            {fw_count_wr, fw_data_wr} <= {cnt, !cnt};
            @(posedge aclk);
        end
        {fw_count_wr, fw_data_wr} <= 2'h0;
        @(posedge aclk);
    endtask : fw

    // Engine request: 1 read, 2 IN token, 4 start of frame
    task automatic usb(input logic [2:0] k);
        rq <= k;
        @(posedge aclk);
        rq <= 3'h0;
        repeat (3) @(posedge aclk);
    endtask : usb

    task automatic complete_run;
        $display("checks=%0d errors=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    // Run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge aclk);
        err_count++;
        complete_run;
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, fw_data_wr, fw_count_wr} = 8'h00;
        {awaddr, araddr, wdata, wstrb, tx_set_index, rq} = '0;
        wstrb = 4'hF;
        err_count = 0;
        checked = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(FLG); chk(rv & 32'hFF, 32'h08);
        rd(8'h18); chk(32'(rr), 32'(tx_fifo_err_pkg::RESP_SLVERR));
        wr(8'h18, 32'h0); chk(32'(rb), 32'(tx_fifo_err_pkg::RESP_SLVERR));
        wr(tx_fifo_err_pkg::IRQ_ENABLE_ADDR, 32'h3);
        fw(64, 1'b0); chk(32'(tx_full_flag), 32'h1);
        rd(FLG); chk(rv & 32'h0F, 32'h04);
        fw(1, 1'b0);
        rd(FLG); chk(rv & 32'h0F, 32'h05);
        chk(32'(irq), 32'h1);
        wr(FLG, 32'h0);
        wr(tx_fifo_err_pkg::IRQ_CLEAR_ADDR, 32'h3);
        rd(FLG); chk(rv & 32'h0F, 32'h05);
        chk(32'(irq), 32'h0);
        usb(3'h2); chk(32'(naks), 32'h1);
        wr(CTL, 32'h1);
        rd(FLG); chk(rv & 32'h0F, 32'h08);
        // More engine reads than bytes loaded, to provoke an underrun
        fw(2, 1'b0);
        repeat (3) usb(3'h1);
        rd(FLG); chk(rv & 32'h03, 32'h02);
        usb(3'h2); chk(32'(naks), 32'h2);
        wr(CTL, 32'h1);
        wr(CTL, 32'h2);
        usb(3'h1);
        rd(FLG); chk(rv & 32'h03, 32'h00);
        usb(3'h4);
        rd(FLG); chk(rv & 32'h03, 32'h02);
        wr(CTL, 32'h3);
        rd(FLG); chk(rv & 32'h01, 32'h00);
        tx_set_index <= 2'h3;
        fw(1, 1'b1);
        rd(FLG); chk(rv & 32'hC3, 32'hC1);
        complete_run;
    end
endmodule : usb_tx_fifo_error_flags_test
`default_nettype wire
